// ### hdl/dtcs_pkg.sv
// package for the transfer channel status block
`default_nettype none
package dtcs_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TR_W = 32;
  localparam logic [11:0] STATUS_OFFSET = 12'h000;
  localparam logic [11:0] CFG_OFFSET = 12'h004;
  localparam int unsigned HEAD_LSB = 11;
  localparam int unsigned ONE_BIT = 8;
  localparam int unsigned COUNT_LSB = 4;
  localparam int unsigned WSP_BIT = 2;
  localparam int unsigned SRC_BIT = 1;
  localparam int unsigned PROG_BIT = 0;
  localparam int unsigned DEPTH_LSB = 8;
  localparam logic [1:0] DEPTH_CFG_FOUR = 2'h2;
  localparam logic [2:0] FIFO_FULL_COUNT = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0100;
  localparam logic [7:0] WS_MAX = 8'hff;
  typedef struct packed {
    logic [1:0] head;
    logic [2:0] count;
    logic wsp;
    logic src;
    logic prog;
  } dtcs_status_t;
endpackage : dtcs_pkg
`default_nettype wire

// ### hdl/dtcs_top.sv
// status tracking for a transfer controller: program set, source set, destination fifo
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - head entry offset reported at bits 12:11
// R2 - status bit 8 always reads one
// R3 - destination request count at bits 6:4
// R4 - full means four entries at depth four
// R5 - empty fifo takes program request immediately
// R6 - partial fifo takes request only when source idle
// R7 - full fifo holds requests back
// R8 - head completion frees one entry
// R9 - pending bit while write status outstanding
// R10 - source active while servicing, else zero
// R11 - program busy zero when set accepts
// R12 - other bits zero, status writes ignored
module dtcs_top #(
  parameter int unsigned TR_W = dtcs_pkg::TR_W
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic tr_valid, // channel controller writes a request
  input wire logic [TR_W-1:0] tr_data, // request payload
  output logic program_set_busy, // program set holds a request
  input wire logic src_done, // source side finished its request
  output logic source_active, // source controller busy
  output logic [TR_W-1:0] src_tr, // request in source active set
  input wire logic head_done, // request at fifo head completed
  output logic [TR_W-1:0] head_tr, // request at fifo head
  output logic head_valid, // fifo holds a request
  input wire logic wr_issue, // write command issued
  input wire logic wr_status, // write status returned
  output logic write_status_pending // writes await status
);
  ////////////////////////////////////////////////////////////////////////////
  logic [TR_W-1:0] prog_r;
  logic prog_busy_r;
  logic src_busy_r;
  logic [TR_W-1:0] src_r;
  logic [TR_W-1:0] fifo_mem [4];
  logic [1:0] head_r;
  logic [2:0] count_r;
  logic [7:0] ws_cnt_r;
  logic [1:0] dest_fifo_depth_cfg_r;
  logic fifo_full;
  logic fifo_empty;
  logic move;
  logic pop;
  logic [1:0] tail;
  dtcs_pkg::dtcs_status_t st;
  logic [31:0] status_word;

  // full only counts when depth is configured for four entries
  assign fifo_full = (count_r == dtcs_pkg::FIFO_FULL_COUNT) &&
    (dest_fifo_depth_cfg_r == dtcs_pkg::DEPTH_CFG_FOUR); // [R4]
  assign fifo_empty = (count_r == 3'h0);
  // request moves into the fifo and the source set together
  // only four slots exist, so a depth code other than four cannot grow the fifo past them
  assign move = prog_busy_r && !fifo_full && (count_r != dtcs_pkg::FIFO_FULL_COUNT) &&
    (fifo_empty || !src_busy_r); // [R5] [R6] [R7]
  assign pop = head_done && !fifo_empty; // [R8]
  assign tail = head_r + count_r[1:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prog_busy_r <= 1'b0;
      prog_r <= '0;
    end
    else if (tr_valid && !prog_busy_r)
    begin
      prog_busy_r <= 1'b1; // [R11]
      prog_r <= tr_data;
    end
    else if (move)
    begin
      prog_busy_r <= 1'b0; // [R11]
    end
  end

  // source set keeps the last request after it goes idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_busy_r <= 1'b0;
      src_r <= '0;
    end
    else if (move)
    begin
      src_busy_r <= 1'b1; // [R10]
      src_r <= prog_r;
    end
    else if (src_done)
    begin
      src_busy_r <= 1'b0; // [R10]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (move)
    begin
      fifo_mem[tail] <= prog_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      head_r <= 2'h0;
      count_r <= 3'h0;
    end
    else
    begin
      if (pop)
      begin
        head_r <= head_r + 2'h1; // [R1] [R8]
      end
      count_r <= count_r + {2'h0, move} - {2'h0, pop}; // [R3]
    end
  end

  // counter saturates; a write and its status in one cycle cancel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ws_cnt_r <= 8'h00;
    end
    else if (wr_issue && !wr_status && ws_cnt_r != dtcs_pkg::WS_MAX)
    begin
      ws_cnt_r <= ws_cnt_r + 8'h01; // [R9]
    end
    else if (wr_status && !wr_issue && ws_cnt_r != 8'h00)
    begin
      ws_cnt_r <= ws_cnt_r - 8'h01; // [R9]
    end
  end

  assign program_set_busy = prog_busy_r;
  assign source_active = src_busy_r;
  assign src_tr = src_r;
  assign head_tr = fifo_mem[head_r];
  assign head_valid = !fifo_empty;
  assign write_status_pending = (ws_cnt_r != 8'h00); // [R9]

  always_comb
  begin
    st.head = head_r;
    st.count = count_r;
    st.wsp = write_status_pending;
    st.src = src_busy_r;
    st.prog = prog_busy_r;
    status_word = dtcs_pkg::STATUS_RESET; // [R2] [R12]
    status_word[dtcs_pkg::HEAD_LSB +: 2] = st.head; // [R1]
    status_word[dtcs_pkg::COUNT_LSB +: 3] = st.count; // [R3]
    status_word[dtcs_pkg::WSP_BIT] = st.wsp; // [R9]
    status_word[dtcs_pkg::SRC_BIT] = st.src; // [R10]
    status_word[dtcs_pkg::PROG_BIT] = st.prog; // [R11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one outstanding write and one read
  logic aw_got_r;
  logic w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dtcs_pkg::RESP_OKAY;
      dest_fifo_depth_cfg_r <= dtcs_pkg::DEPTH_CFG_FOUR;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r[11:2] == dtcs_pkg::CFG_OFFSET[11:2])
        begin
          s_axi_bresp <= dtcs_pkg::RESP_OKAY;
          if (wstrb_r[1])
          begin
            dest_fifo_depth_cfg_r <= wdata_r[dtcs_pkg::DEPTH_LSB +: 2];
          end
        end
        else if (awaddr_r[11:2] == dtcs_pkg::STATUS_OFFSET[11:2])
        begin
          s_axi_bresp <= dtcs_pkg::RESP_OKAY; // [R12]
        end
        else
        begin
          s_axi_bresp <= dtcs_pkg::RESP_SLVERR;
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dtcs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[11:2] == dtcs_pkg::STATUS_OFFSET[11:2])
      begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= dtcs_pkg::RESP_OKAY;
      end
      else if (s_axi_araddr[11:2] == dtcs_pkg::CFG_OFFSET[11:2])
      begin
        s_axi_rdata <= {22'h0, dest_fifo_depth_cfg_r, 8'h00};
        s_axi_rresp <= dtcs_pkg::RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= dtcs_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_ONE_BIT: assert property (@(posedge aclk) disable iff (!aresetn) // [R2] [R12]
    status_word[8] && status_word[31:13] == '0 && status_word[10:9] == '0 &&
      !status_word[7] && !status_word[3])
    else $error("status reserved bits wrong");
  AST_COUNT_MAX: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    count_r <= 3'h4)
    else $error("fifo count above four");
  AST_FULL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    fifo_full && !pop |=> count_r == 3'h4)
    else $error("full fifo admitted a request");
  AST_EMPTY_MOVE: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    prog_busy_r && fifo_empty |=> !prog_busy_r && count_r == 3'h1)
    else $error("empty fifo did not take request");
  AST_SRC_BUSY_WAIT: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    prog_busy_r && !fifo_empty && src_busy_r |=> prog_busy_r)
    else $error("request moved while source busy");
  AST_POP_HEAD: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    pop |=> head_r == $past(head_r) + 2'h1)
    else $error("head did not advance");
  AST_HEAD_STILL: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    !head_done |=> $stable(head_r))
    else $error("head moved without completion");
  AST_WS_SET: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    wr_issue && !wr_status |=> write_status_pending)
    else $error("pending not set on issue");
  AST_SRC_ON: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    move |=> source_active && src_tr == $past(prog_r))
    else $error("source set not loaded");
  AST_PROG_TAKE: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    tr_valid && !prog_busy_r |=> program_set_busy)
    else $error("program set not busy after write");
  AST_WR_OK: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    aw_got_r && w_got_r && awaddr_r[11:2] == dtcs_pkg::STATUS_OFFSET[11:2]
      |=> s_axi_bvalid && s_axi_bresp == dtcs_pkg::RESP_OKAY)
    else $error("status write refused");
  COV_FULL: cover property (@(posedge aclk) disable iff (!aresetn) fifo_full);
  COV_POP_FULL: cover property (@(posedge aclk) disable iff (!aresetn) fifo_full && pop);
  COV_WS: cover property (@(posedge aclk) disable iff (!aresetn) ws_cnt_r == 8'h02);
  COV_READ: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready);
endmodule : dtcs_top
`default_nettype wire

// ### test/dtcs_chan_model.sv
// channel controller model that offers transfer requests
`default_nettype none
module dtcs_chan_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic req, // bench asks for one request
  input wire logic [31:0] req_data, // payload to offer
  input wire logic program_set_busy, // program set state
  output logic tr_valid, // request offered
  output logic [31:0] tr_data // request payload
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tr_valid <= 1'b0;
      tr_data <= 32'h0000_0000;
    end
    else if (tr_valid && !program_set_busy)
    begin
      tr_valid <= 1'b0;
      tr_data <= ~tr_data; // stale payload must not look like the last one
    end
    else if (req && !tr_valid)
    begin
      tr_valid <= 1'b1;
      tr_data <= req_data;
    end
  end
endmodule : dtcs_chan_model
`default_nettype wire

// ### test/dtcs_top_test.sv
// testbench for the transfer channel status block
`default_nettype none
module dtcs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tr_valid, busy, src_act, head_valid, wsp;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, tr_data, src_tr, head_tr, d;
  logic req = 1'b0;
  logic [31:0] req_data = 32'h0000_0000;
  logic [3:0] ev = 4'h0;
  int mismatches = 0;
  int compares = 0;
  always #2 aclk = ~aclk;
  dtcs_top #(.TR_W(32)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tr_valid(tr_valid), .tr_data(tr_data), .program_set_busy(busy), .src_done(ev[0]),
    .source_active(src_act), .src_tr(src_tr), .head_done(ev[1]), .head_tr(head_tr),
    .head_valid(head_valid), .wr_issue(ev[2]), .wr_status(ev[3]),
    .write_status_pending(wsp));
  dtcs_chan_model ctl (.aclk(aclk), .aresetn(aresetn), .req(req), .req_data(req_data),
    .program_set_busy(busy), .tr_valid(tr_valid), .tr_data(tr_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // handshakes are sampled mid-cycle so the edge updates of the design never race
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb)
      begin
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr)
      begin
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  function automatic logic [31:0] sv(input int h, input int c, input int w, input int s,
    input int p);
    return 32'h0000_0100 | 32'((h << 11) | (c << 4) | (w << 2) | (s << 1) | p);
  endfunction : sv
  task automatic chk_st(input logic [31:0] exp);
    rd(12'h000, d, r);
    chk(d, exp);
  endtask : chk_st
  task automatic snd(input logic [31:0] v);
    @(posedge aclk);
    req <= 1'b1;
    req_data <= v;
    @(posedge aclk);
    req <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : snd
  task automatic pls(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask : pls
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20000;
    mismatches++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000, d, r);
    chk(d, 32'h0000_0100);
    chk(32'(r), 32'(dtcs_pkg::RESP_OKAY));
    chk(32'(head_valid), 32'h0000_0000);
    rd(12'h004, d, r);
    chk(d, 32'h0000_0200);
    wr(12'h004, 32'h0000_0300, r);
    chk(32'(r), 32'(dtcs_pkg::RESP_OKAY));
    rd(12'h004, d, r);
    chk(d, 32'h0000_0300);
    wr(12'h004, 32'h0000_0200, r);
    rd(12'h004, d, r);
    chk(d, 32'h0000_0200);
    wr(12'h000, 32'hffff_ffff, r);
    chk(32'(r), 32'(dtcs_pkg::RESP_OKAY));
    chk_st(sv(0, 0, 0, 0, 0));
    rd(12'h010, d, r);
    chk(32'(r), 32'(dtcs_pkg::RESP_SLVERR));
    chk(d, 32'h0000_0000);
    $display("test registers done");
    snd(32'h0000_00a0);
    chk_st(sv(0, 1, 0, 1, 0));
    chk(src_tr, 32'h0000_00a0);
    snd(32'h0000_00a1);
    chk_st(sv(0, 1, 0, 1, 1));
    pls(0);
    chk_st(sv(0, 2, 0, 1, 0));
    for (int k = 2; k < 4; k++)
    begin
      pls(0);
      snd(32'h0000_00a0 + 32'(k));
    end
    chk_st(sv(0, 4, 0, 1, 0));
    pls(0);
    snd(32'h0000_00a4);
    chk_st(sv(0, 4, 0, 0, 1));
    pls(1);
    chk_st(sv(1, 4, 0, 1, 0));
    chk(head_tr, 32'h0000_00a1);
    chk(32'(head_valid), 32'h0000_0001);
    chk(src_tr, 32'h0000_00a4);
    $display("test fifo done");
    pls(2);
    pls(2);
    pls(3);
    chk_st(sv(1, 4, 1, 1, 0));
    pls(3);
    chk_st(sv(1, 4, 0, 1, 0));
    chk(32'(wsp), 32'h0000_0000);
    $display("test write status done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_st(sv(0, 0, 0, 0, 0));
    chk(32'(head_valid), 32'h0000_0000);
    chk(src_tr, 32'h0000_0000);
    $display("test reset done");
    close_out();
  end
endmodule : dtcs_top_test
`default_nettype wire
